// File: hw/fws_pkg.sv
// package: constants and types for the flash status polling controller
// Overview of operation
// - host reads status at the program address
// - host reads erase status inside erased sector
// - take valid data only on later read
// - host compares toggle over two back-to-back reads
// - toggling with timeout bit: recheck, then reset
// - resumed polling restarts from first paired read
// - host writes reset command after timeout failure
// - reset is one write of f0 anywhere
package fws_pkg;
  localparam int ADDR_W = 18;
  localparam int CLK_MHZ = 20;
  // bus timing in cycles: setup, strobe low, hold/recovery
  localparam logic [3:0] SETUP_CYC = 4'h1;
  localparam logic [3:0] STROBE_CYC = 4'h3;
  localparam logic [3:0] RECOV_CYC = 4'h2;
  localparam logic [7:0] RESET_CMD = 8'hf0;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TIMEOUT_BIT = 5;
  // register map of the controller, word offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_RDAT = 4'h4;
  // ctrl write bits
  localparam int CTRL_WRITE = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_TOGGLE = 2;
  localparam int CTRL_POLL = 3;
  localparam int CTRL_RESET = 4;
  localparam int CTRL_EXPECT = 8;
  // poll/toggle results
  typedef enum logic [1:0] {FWS_RES_NONE, FWS_RES_DONE, FWS_RES_FAIL}
    fws_res_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic write;
  } fws_cyc_t;
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0] dout;
    logic doe;
  } fws_pins_t;
endpackage : fws_pkg

// File: hw/fws_bus_cycle.sv
// one flash bus cycle (read or write) driven on the strobe pins
`timescale 1ns/1ps
`default_nettype none
module fws_bus_cycle
  import fws_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // request
  input wire logic start,
  input wire fws_pkg::fws_cyc_t cyc,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  // pins
  output fws_pkg::fws_pins_t pins,
  input wire logic [7:0] din
);
  typedef enum {FWS_IDLE, FWS_SETUP, FWS_STROBE, FWS_RECOV} fws_bst_t;
  fws_bst_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] s1_q, s2_q, s3_q;
  logic [7:0] stab_q, stab_d;

  // a pin bit counts only once the two late stages agree on it
  for (genvar gi = 0; gi < 8; gi++)
  begin : g_agree
    assign stab_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : stab_q[gi];
  end

  // three-stage sampler; value taken only once last two agree
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      s3_q <= 8'h00;
      stab_q <= 8'h00;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      stab_q <= stab_d;
    end

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      st_q <= FWS_IDLE;
      cnt_q <= 4'h0;
      done <= 1'b0;
      rdata <= 8'h00;
      pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
    end
    else
    begin
      done <= 1'b0;
      case (st_q)
        FWS_IDLE:
          if (start)
          begin
            pins.addr <= cyc.addr;
            pins.dout <= cyc.data;
            pins.doe <= cyc.write;
            pins.ce_n <= 1'b0;
            cnt_q <= SETUP_CYC;
            st_q <= FWS_SETUP;
          end
        FWS_SETUP:
          if (cnt_q == 4'h1)
          begin
            pins.we_n <= ~pins.doe;
            pins.oe_n <= pins.doe;
            cnt_q <= STROBE_CYC;
            st_q <= FWS_STROBE;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        FWS_STROBE:
          if (cnt_q == 4'h1)
          begin
            // each read ends at oe rise: device toggles once here
            pins.we_n <= 1'b1;
            pins.oe_n <= 1'b1;
            pins.ce_n <= 1'b1;
            cnt_q <= RECOV_CYC;
            st_q <= FWS_RECOV;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        FWS_RECOV:
          if (cnt_q == 4'h1)
          begin
            // stages lag the pin by three clocks: byte settles only now
            rdata <= stab_d;
            pins.doe <= 1'b0;
            done <= 1'b1;
            st_q <= FWS_IDLE;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        default:
          st_q <= FWS_IDLE;
      endcase
    end

  assign busy = (st_q != FWS_IDLE);
endmodule : fws_bus_cycle
`default_nettype wire

// File: hw/fws_host.sv
// host controller: flash command writes, data polling, toggle check
`timescale 1ns/1ps
`default_nettype none
module fws_host
  import fws_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // software port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // flash pins
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] data_byte_lines_out,
  output logic data_byte_lines_oe,
  input wire logic [7:0] data_byte_lines_in
);
  typedef enum {H_IDLE, H_ONE, H_RD_A, H_RD_B, H_RD_C, H_RESET, H_CHECK}
    fws_hst_t;

  logic rst_a_q, rst_n;
  fws_hst_t st_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] data_q, first_q, rdat_q;
  logic expect_q, poll_mode_q, seen_to_q, busy_q;
  fws_res_t res_q;
  logic cyc_start_q, cyc_busy, cyc_done;
  fws_cyc_t cyc_q;
  fws_pins_t pins;
  logic [7:0] cyc_rdata;
  logic tog_diff, poll_true;

  // ****************************************************************
  // reset release
  // ****************************************************************
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      rst_a_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_a_q <= 1'b1;
      rst_n <= rst_a_q;
    end

  fws_bus_cycle u_cyc (
    .clock(clock),
    .rst_n(rst_n),
    .start(cyc_start_q),
    .cyc(cyc_q),
    .busy(cyc_busy),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .pins(pins),
    .din(data_byte_lines_in)
  );

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_addr <= '0;
      data_byte_lines_out <= 8'h00;
      data_byte_lines_oe <= 1'b0;
    end
    else
    begin
      flash_ce_n <= pins.ce_n;
      flash_we_n <= pins.we_n;
      flash_oe_n <= pins.oe_n;
      flash_addr <= pins.addr;
      data_byte_lines_out <= pins.dout;
      data_byte_lines_oe <= pins.doe;
    end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      addr_q <= '0;
      data_q <= 8'h00;
    end
    else if (reg_wr && !busy_q)
    begin
      if (reg_addr == REG_ADDR)
        addr_q <= reg_wdata[ADDR_W-1:0];
      if (reg_addr == REG_DATA)
        data_q <= reg_wdata[7:0];
    end

  assign tog_diff = (first_q[TOGGLE_BIT] != cyc_rdata[TOGGLE_BIT]);
  assign poll_true = (cyc_rdata[POLL_BIT] == expect_q);

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // polling reads always use addr_q: program address or erase sector
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      st_q <= H_IDLE;
      cyc_start_q <= 1'b0;
      cyc_q <= '0;
      busy_q <= 1'b0;
      res_q <= FWS_RES_NONE;
      first_q <= 8'h00;
      rdat_q <= 8'h00;
      expect_q <= 1'b0;
      poll_mode_q <= 1'b0;
      seen_to_q <= 1'b0;
    end
    else
    begin
      cyc_start_q <= 1'b0;
      case (st_q)
        H_IDLE:
          if (reg_wr && reg_addr == REG_CTRL)
          begin
            busy_q <= 1'b1;
            res_q <= FWS_RES_NONE;
            seen_to_q <= 1'b0;
            expect_q <= reg_wdata[CTRL_EXPECT];
            cyc_start_q <= 1'b1;
            cyc_q.addr <= addr_q;
            cyc_q.data <= data_q;
            cyc_q.write <= 1'b0;
            if (reg_wdata[CTRL_WRITE])
            begin
              cyc_q.write <= 1'b1;
              st_q <= H_ONE;
            end
            else if (reg_wdata[CTRL_RESET])
            begin
              cyc_q.write <= 1'b1;
              cyc_q.data <= RESET_CMD;
              st_q <= H_ONE;
            end
            else if (reg_wdata[CTRL_TOGGLE] || reg_wdata[CTRL_POLL])
            begin
              // always restart from the first paired read
              poll_mode_q <= reg_wdata[CTRL_POLL];
              st_q <= H_RD_A;
            end
            else if (reg_wdata[CTRL_READ])
              st_q <= H_ONE;
            else
            begin
              cyc_start_q <= 1'b0;
              busy_q <= 1'b0;
            end
          end
        H_ONE:
          if (cyc_done)
          begin
            rdat_q <= cyc_rdata;
            res_q <= FWS_RES_DONE;
            busy_q <= 1'b0;
            st_q <= H_IDLE;
          end
        H_RD_A:
          if (cyc_done)
          begin
            first_q <= cyc_rdata;
            cyc_start_q <= 1'b1;
            st_q <= H_RD_B;
          end
        H_RD_B:
          if (cyc_done)
          begin
            rdat_q <= cyc_rdata;
            first_q <= cyc_rdata;
            if (poll_mode_q ? poll_true : !tog_diff)
            begin
              // true bit seen or toggling stopped: data taken from a further read
              cyc_start_q <= 1'b1;
              st_q <= H_RD_C;
            end
            else if (seen_to_q)
              st_q <= H_RESET;
            else
            begin
              seen_to_q <= cyc_rdata[TIMEOUT_BIT];
              cyc_start_q <= 1'b1;
              st_q <= seen_to_q ? H_RESET : H_CHECK;
            end
          end
        H_CHECK:
        begin
          // recheck once more after timeout bit, else keep polling
          cyc_start_q <= 1'b1;
          st_q <= H_RD_B;
        end
        H_RD_C:
          if (cyc_done)
          begin
            rdat_q <= cyc_rdata;
            res_q <= FWS_RES_DONE;
            busy_q <= 1'b0;
            st_q <= H_IDLE;
          end
        H_RESET:
          if (!cyc_busy && !cyc_start_q)
          begin
            cyc_start_q <= 1'b1;
            cyc_q.write <= 1'b1;
            cyc_q.data <= RESET_CMD;
            res_q <= FWS_RES_FAIL;
            st_q <= H_ONE;
          end
        default:
          st_q <= H_IDLE;
      endcase
      if (st_q == H_ONE && cyc_done && res_q == FWS_RES_FAIL)
        res_q <= FWS_RES_FAIL;
    end

  // ****************************************************************
  // read port
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      case (reg_addr)
        REG_ADDR: reg_rdata <= {{(32-ADDR_W){1'b0}}, addr_q};
        REG_DATA: reg_rdata <= {24'h000000, data_q};
        REG_STAT: reg_rdata <= {28'h0000000, res_q, seen_to_q, busy_q};
        REG_RDAT: reg_rdata <= {24'h000000, rdat_q};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    else
      reg_rdata <= 32'h0000_0000;
endmodule : fws_host
`default_nettype wire

// File: tb/fws_host_monitor.sv
// checker of the flash pin protocol driven by the host controller
`timescale 1ns/1ps
`default_nettype none
module fws_host_monitor
  import fws_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // flash pins
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic data_byte_lines_oe
);
  // ***
  // pin relations
  // ***
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  property p_excl;
    flash_we_n || flash_oe_n;
  endproperty
  a_excl: assert property (p_excl) else $error("strobes overlap");
  property p_wr_len;
    $fell(flash_we_n) |-> (!flash_we_n)[*3] ##1 flash_we_n;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write length");
  property p_rd_len;
    $fell(flash_oe_n) |-> (!flash_oe_n)[*3] ##1 flash_oe_n;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read length");
  property p_frame;
    !(flash_we_n && flash_oe_n) |-> !flash_ce_n;
  endproperty
  a_frame: assert property (p_frame) else $error("strobe unframed");
  property p_setup;
    $fell(flash_oe_n) || $fell(flash_we_n) |-> !$past(flash_ce_n);
  endproperty
  a_setup: assert property (p_setup) else $error("no select setup");
  // status read at a moving address would be meaningless
  property p_addr;
    !flash_oe_n && !$past(flash_oe_n) |-> $stable(flash_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_rd_hiz;
    !flash_oe_n |-> !data_byte_lines_oe;
  endproperty
  a_rd_hiz: assert property (p_rd_hiz) else $error("bus contention");
  property p_wr_drv;
    !flash_we_n |-> data_byte_lines_oe;
  endproperty
  a_wr_drv: assert property (p_wr_drv) else $error("write undriven");
  c_wr: cover property ($fell(flash_we_n));
  c_rd: cover property ($fell(flash_oe_n));
  c_pair: cover property ($rose(flash_oe_n) ##[1:8] $fell(flash_oe_n));
endmodule : fws_host_monitor
bind fws_host fws_host_monitor i_fws_host_monitor (.clock, .rstn,
  .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_addr, .data_byte_lines_oe);
`default_nettype wire

// File: tb/fws_flash_model.sv
// behavioural flash device giving status during embedded operations
`timescale 1ns/1ps
`default_nettype none
module fws_flash_model
  import fws_pkg::*;
(
  // pins
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] d,
  output logic [7:0] q,
  // bench control
  input wire logic load,
  input wire logic [7:0] nbusy,
  input wire logic fail,
  input wire logic [7:0] pd,
  output logic [ADDR_W-1:0] ra,
  output logic [7:0] wd,
  output logic rst_seen
);
  // ***
  // status engine
  // ***
  logic [7:0] cnt = 8'h0;
  logic fl = 1'b0;
  logic tog = 1'b0;
  logic [7:0] last = 8'h0;
  wire busy = (cnt != 8'h0) || fl;
  wire [7:0] st = {~pd[7], tog, fl, 2'h0, tog, 2'h0};
  initial
  begin
    ra = '0;
    wd = 8'h0;
    rst_seen = 1'b0;
  end
  // busy time stands for protected or real operations
  always @(posedge load)
  begin
    cnt = nbusy;
    fl = fail;
    rst_seen = 1'b0;
  end
  always @(negedge oe_n) ra = addr;
  always @(posedge oe_n)
  begin
    last = busy ? st : pd;
    if (busy)
      tog = ~tog;
    if (cnt != 8'h0)
      cnt = cnt - 8'h1;
  end
  always @(posedge we_n)
  begin
    wd = d;
    if (d == RESET_CMD)
    begin
      fl = 1'b0;
      cnt = 8'h0;
      rst_seen = 1'b1;
    end
  end
  // released bus shows the inverse, never a stale byte
  always @*
  begin
    if (!ce_n && !oe_n)
      q = busy ? st : pd;
    else
      q = ~last;
  end
endmodule : fws_flash_model
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the flash status polling host
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fws_pkg::*;
  typedef struct packed {
    logic [7:0] nb;
    logic fl;
    logic [7:0] pd;
    logic [31:0] ctrl;
    logic [1:0] res;
  } fws_row_t;
  localparam fws_row_t ROWS [5] = '{
    '{8'h0, 1'b0, 8'h5a, 32'h4, FWS_RES_DONE},
    '{8'h5, 1'b0, 8'h3c, 32'h4, FWS_RES_DONE},
    '{8'h4, 1'b0, 8'h80, 32'h108, FWS_RES_DONE},
    '{8'h2, 1'b0, 8'h01, 32'h8, FWS_RES_DONE},
    '{8'h0, 1'b1, 8'h00, 32'h4, FWS_RES_FAIL}};
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic load = 1'b0;
  logic fail = 1'b0;
  logic [7:0] nbusy = 8'h0;
  logic [7:0] pd = 8'h0;
  logic [31:0] reg_rdata, r;
  logic ce_n, we_n, oe_n, doe, rst_seen;
  logic [ADDR_W-1:0] fa, ra;
  logic [7:0] dout, q, wd;
  wire [7:0] dq = doe ? dout : q;
  int n_mismatch = 0;
  int num_checks = 0;
  fws_host i_fws_host (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .flash_ce_n(ce_n), .flash_we_n(we_n),
    .flash_oe_n(oe_n), .flash_addr(fa), .data_byte_lines_out(dout),
    .data_byte_lines_oe(doe), .data_byte_lines_in(dq));
  fws_flash_model i_fws_flash_model (.ce_n, .we_n, .oe_n, .addr(fa),
    .d(dq), .q, .load, .nbusy, .fail, .pd, .ra, .wd, .rst_seen);
  always #25 clock = ~clock;
  // ***
  // tasks
  // ***
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask : rd
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic wait_idle;
    for (int i = 0; i < 400; i++)
    begin
      rd(REG_STAT, r);
      if (r[0] === 1'b0)
        return;
    end
    chk("idle", 32'h0, 32'h1);
    end_of_test();
  endtask : wait_idle
  // ***
  // sequence
  // ***
  initial
  begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    rd(REG_STAT, r);
    chk("stat_reset", 32'h0, r);
    foreach (ROWS[k])
    begin
      nbusy <= ROWS[k].nb;
      fail <= ROWS[k].fl;
      pd <= ROWS[k].pd;
      load <= 1'b0;
      @(posedge clock) load <= 1'b1;
      wr(REG_ADDR, 32'h1200 + k);
      wr(REG_CTRL, ROWS[k].ctrl);
      // refused while busy: the status reads must stay put
      wr(REG_ADDR, 32'h0);
      wait_idle();
      rd(REG_STAT, r);
      chk("result", ROWS[k].res, r[3:2]);
      chk("timeout_seen", ROWS[k].fl, r[1]);
      chk("read_addr", 32'h1200 + k, ra);
      chk("reset_sent", ROWS[k].fl, rst_seen);
      rd(REG_RDAT, r);
      if (!ROWS[k].fl)
        chk("array_data", ROWS[k].pd, r);
    end
    wr(REG_ADDR, 32'h2aaaa);
    wr(REG_DATA, 32'ha5);
    wr(REG_CTRL, 32'h1);
    wait_idle();
    chk("write_data", 32'ha5, wd);
    wr(REG_CTRL, 32'h10);
    wait_idle();
    chk("reset_data", RESET_CMD, wd);
    rd(REG_DATA, r);
    chk("data_reg", 32'ha5, r);
    // plain array read through the read command
    pd <= 8'h69;
    wr(REG_CTRL, 32'h2);
    wait_idle();
    rd(REG_RDAT, r);
    chk("plain_read", 32'h69, r);
    chk("plain_addr", 32'h2aaaa, ra);
    // reset cut into a running toggle check
    nbusy <= 8'h40;
    fail <= 1'b0;
    load <= 1'b0;
    @(posedge clock) load <= 1'b1;
    wr(REG_CTRL, 32'h4);
    repeat (6) @(posedge clock);
    rstn <= 1'b0;
    @(negedge clock);
    chk("reset_pins", 32'h7, {ce_n, we_n, oe_n});
    chk("reset_drive", 32'h0, doe);
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    rd(REG_STAT, r);
    chk("stat_midrun", 32'h0, r);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
